// ---- inc/spd_pkg.sv ----
// spd_pkg: widths, field positions, reset values and ratio table of the synthesizer core
package spd_pkg;

	// ************************************************************
	// word layout
	// ************************************************************
	localparam int SPD_WORD_W  = 17;
	localparam int SPD_SWAL_W  = 7;
	localparam int SPD_PROG_W  = 10;
	localparam int SPD_SWAL_LSB = 0;
	localparam int SPD_PROG_LSB = 7;

	// ************************************************************
	// reset values
	// ************************************************************
	// latch wakes up with prog = 5, swallow = 0, the smallest legal setting
	localparam logic [16:0] SPD_LATCH_RST = 17'h00280;
	localparam logic [16:0] SPD_SHIFT_RST = 17'h00000;
	localparam logic [9:0]  SPD_PROG_ONE  = 10'h001;
	localparam logic [6:0]  SPD_SWAL_ZERO = 7'h00;

	// ************************************************************
	// input synchroniser and reference divider
	// ************************************************************
	localparam int SPD_SYNC_W = 8;
	localparam int SPD_SEL_W  = 3;
	localparam int SPD_REF_W  = 11;
	localparam logic [10:0] SPD_REF_ZERO = 11'h000;

	// terminal counts (ratio minus one) for 1/8 .. 1/2048, ascending select code
	localparam logic [10:0] SPD_REF_LAST [8] = '{
		11'h007, 11'h00f, 11'h03f, 11'h07f,
		11'h0ff, 11'h1ff, 11'h3ff, 11'h7ff
	};

	// phase detector states
	typedef enum logic [1:0] {
		SPD_PFD_IDLE,
		SPD_PFD_UP,
		SPD_PFD_DN
	} spd_pfd_t;

	// select code to reference terminal count
	function automatic logic [10:0] spd_ref_last(input logic [2:0] sel);
		spd_ref_last = SPD_REF_LAST[sel];
	endfunction

endpackage

// ---- rtl/spd_ref_divider.sv ----
// spd_ref_divider: oscillator edge divider with eight selectable ratios
module spd_ref_divider (
	// clock and reset
	input  logic                           clk,
	input  logic                           rst_n,
	// oscillator edge enable and ratio select
	input  logic                           osc_rise,
	input  logic [spd_pkg::SPD_SEL_W-1:0]  ratio_sel,
	// divided output
	output logic                           ref_pulse
);
	import spd_pkg::*;

	logic [SPD_REF_W-1:0] cnt_r;
	logic [SPD_REF_W-1:0] cnt_nxt;
	logic                 pulse_r;
	logic                 pulse_nxt;
	logic                 at_end;
	logic [SPD_REF_W-1:0] last_cnt;

	// ************************************************************
	// down counter
	// ************************************************************
	// a new select takes effect at the next reload, so no short period appears
	assign last_cnt  = spd_ref_last(ratio_sel);
	assign at_end    = osc_rise && (cnt_r == SPD_REF_ZERO);
	assign cnt_nxt   = at_end ? last_cnt : (osc_rise ? cnt_r - 11'h001 : cnt_r);
	assign pulse_nxt = at_end;

	// counter and one-cycle pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r   <= SPD_REF_ZERO;
			pulse_r <= 1'h0;
		end else begin
			cnt_r   <= cnt_nxt;
			pulse_r <= pulse_nxt;
		end
	end

	assign ref_pulse = pulse_r;

	// ************************************************************
	// checks
	// ************************************************************
	a_ref_reload: assert property (@(posedge clk) disable iff (!rst_n)
		at_end |=> (cnt_r == $past(last_cnt)) && pulse_r)
		else $error("reference divider did not reload with the selected ratio");

	a_ref_count: assert property (@(posedge clk) disable iff (!rst_n)
		(osc_rise && cnt_r != SPD_REF_ZERO) |=> (cnt_r == $past(cnt_r) - 11'h001) && !pulse_r)
		else $error("reference divider missed an oscillator edge");

	c_ref_max: cover property (@(posedge clk) disable iff (!rst_n)
		at_end && ratio_sel == 3'h7);

endmodule

// ---- rtl/spd_core.sv ----
// spd_core: serial-programmed pulse-swallow divider, reference divider and phase detector
module spd_core (
	// clock and reset
	input  logic                           clk,
	input  logic                           rst_n,
	// serial programming pins
	input  logic                           ser_clk,
	input  logic                           ser_data,
	input  logic                           latch_transfer_strobe,
	// reference ratio select pins
	input  logic                           ref_ratio_select_0,
	input  logic                           ref_ratio_select_1,
	input  logic                           ref_ratio_select_2,
	// divider inputs
	input  logic                           osc_in,
	input  logic                           prescaler_in,
	// prescaler modulus control
	output logic                           mod_ctrl,
	// divided frequency monitors
	output logic                           reference_divided_freq,
	output logic                           feedback_divided_freq,
	// on-chip three-state pump
	output logic                           pump_out,
	output logic                           pump_oe_n,
	// external pump drive
	output logic                           ext_pump_up,
	output logic                           ext_pump_dn,
	// active divide setting
	output logic [spd_pkg::SPD_SWAL_W-1:0] swallow_value,
	output logic [spd_pkg::SPD_PROG_W-1:0] prog_value
);
	import spd_pkg::*;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// ************************************************************
	// input synchronisers
	// ************************************************************
	logic [SPD_SYNC_W-1:0] pin_raw;
	logic [SPD_SYNC_W-1:0] meta_r;
	logic [SPD_SYNC_W-1:0] sync_r;
	logic [SPD_SYNC_W-1:0] prev_r;
	logic [SPD_SYNC_W-1:0] rise;

	assign pin_raw = {ref_ratio_select_2, ref_ratio_select_1, ref_ratio_select_0,
		latch_transfer_strobe, ser_data, ser_clk, prescaler_in, osc_in};

	// every pin crosses two flops; the third stage only feeds edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_r <= '0;
			sync_r <= '0;
			prev_r <= '0;
		end else begin
			meta_r <= pin_raw;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end

	// rising edge of each synchronised pin
	genvar gi;
	generate
		for (gi = 0; gi < SPD_SYNC_W; gi++) begin : g_edge
			assign rise[gi] = sync_r[gi] & ~prev_r[gi];
		end
	endgenerate

	// named views of the synchronised pins
	logic                 osc_rise;
	logic                 fin_rise;
	logic                 sclk_rise;
	logic                 sdata_s;
	logic                 strobe_s;
	logic [SPD_SEL_W-1:0] sel_s;

	assign osc_rise  = rise[0];
	assign fin_rise  = rise[1];
	assign sclk_rise = rise[2];
	assign sdata_s   = sync_r[3];
	assign strobe_s  = sync_r[4];
	assign sel_s     = sync_r[7:5];

	// ************************************************************
	// serial shift register and latch
	// ************************************************************
	logic [SPD_WORD_W-1:0] shift_r;
	logic [SPD_WORD_W-1:0] shift_nxt;
	logic [SPD_WORD_W-1:0] latch_r;
	logic [SPD_WORD_W-1:0] latch_nxt;

	// first bit in ends in the top position after 17 shifts
	assign shift_nxt = sclk_rise ? {shift_r[SPD_WORD_W-2:0], sdata_s} : shift_r;
	// level-sensitive transfer: shifting during a high strobe flows through
	assign latch_nxt = strobe_s ? shift_r : latch_r;

	// shift and latch storage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			shift_r <= SPD_SHIFT_RST;
			latch_r <= SPD_LATCH_RST;
		end else begin
			shift_r <= shift_nxt;
			latch_r <= latch_nxt;
		end
	end

	a_shift_one_bit: assert property (
		sclk_rise |=> shift_r == {$past(shift_r[SPD_WORD_W-2:0]), $past(sdata_s)})
		else $error("serial edge did not shift exactly one bit");

	a_shift_hold: assert property (
		!sclk_rise |=> shift_r == $past(shift_r))
		else $error("shift register moved without a serial edge");

	a_latch_copy: assert property (
		strobe_s |=> latch_r == $past(shift_r))
		else $error("strobe high but latch not loaded from shift register");

	a_latch_hold: assert property (
		!strobe_s |=> latch_r == $past(latch_r))
		else $error("latch changed while strobe low");

	// ************************************************************
	// divide setting fields
	// ************************************************************
	logic [SPD_SWAL_W-1:0] swal_set;
	logic [SPD_PROG_W-1:0] prog_set;

	// plain binary, no offset or coding
	assign swal_set = latch_r[SPD_SWAL_LSB +: SPD_SWAL_W];
	assign prog_set = latch_r[SPD_PROG_LSB +: SPD_PROG_W];

	// ************************************************************
	// pulse swallow divider
	// ************************************************************
	logic [SPD_PROG_W-1:0] prog_cnt_r;
	logic [SPD_PROG_W-1:0] prog_cnt_nxt;
	logic [SPD_SWAL_W-1:0] swal_cnt_r;
	logic [SPD_SWAL_W-1:0] swal_cnt_nxt;
	logic                  mod_r;
	logic                  mod_nxt;
	logic                  fv_r;
	logic                  fv_due;

	// the last prescaler period of a divide cycle reloads both counters;
	// a programmable value below five is not guarded here, the host avoids it
	assign fv_due = fin_rise && (prog_cnt_r == SPD_PROG_ONE);

	// counters step once per prescaler output rising edge; the swallow counter holds at zero
	assign prog_cnt_nxt = fv_due ? prog_set :
		(fin_rise ? prog_cnt_r - 10'h001 : prog_cnt_r);
	assign swal_cnt_nxt = fv_due ? swal_set :
		((fin_rise && swal_cnt_r != SPD_SWAL_ZERO) ? swal_cnt_r - 7'h01 : swal_cnt_r);

	// high modulus while swallow count remains, so N*M + A input cycles pass
	assign mod_nxt = (swal_cnt_nxt != SPD_SWAL_ZERO);

	// divider state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prog_cnt_r <= SPD_PROG_ONE;
			swal_cnt_r <= SPD_SWAL_ZERO;
			mod_r      <= 1'h0;
			fv_r       <= 1'h0;
		end else begin
			prog_cnt_r <= prog_cnt_nxt;
			swal_cnt_r <= swal_cnt_nxt;
			mod_r      <= mod_nxt;
			fv_r       <= fv_due;
		end
	end

	a_reload_fields: assert property (
		fv_due |=> (prog_cnt_r == $past(prog_set)) && (swal_cnt_r == $past(swal_set)))
		else $error("divider did not reload from the latched fields");

	a_mod_follows: assert property (
		mod_r == (swal_cnt_r != SPD_SWAL_ZERO))
		else $error("modulus control disagrees with swallow count");

	a_mod_drops: assert property (
		(fin_rise && !fv_due && swal_cnt_r == 7'h01) |=> !mod_r)
		else $error("modulus stayed high after swallow count expired");

	a_fv_at_end: assert property (
		fv_due |=> fv_r ##1 !fv_r)
		else $error("divided pulse missing or longer than one cycle");

	a_fv_only_end: assert property (
		fv_r |-> $past(fv_due))
		else $error("divided pulse without terminal count");

	c_swallow_run: cover property (
		fv_due && swal_set != SPD_SWAL_ZERO ##[1:200] fv_due);

	// ************************************************************
	// reference divider
	// ************************************************************
	logic fr_pulse;

	spd_ref_divider u_ref_div (
		.clk       (clk),
		.rst_n     (rst_n),
		.osc_rise  (osc_rise),
		.ratio_sel (sel_s),
		.ref_pulse (fr_pulse)
	);

	// ************************************************************
	// phase detector
	// ************************************************************
	spd_pfd_t pfd_r;
	spd_pfd_t pfd_nxt;

	// an edge arriving with the opposite one cancels it; coincident edges
	// are treated as aligned and leave the pump released
	always_comb begin
		pfd_nxt = pfd_r;
		case (pfd_r)
			SPD_PFD_IDLE: begin
				if (fr_pulse && !fv_r) begin
					pfd_nxt = SPD_PFD_UP;
				end else if (fv_r && !fr_pulse) begin
					pfd_nxt = SPD_PFD_DN;
				end
			end
			SPD_PFD_UP: begin
				if (fv_r) begin
					pfd_nxt = SPD_PFD_IDLE;
				end
			end
			SPD_PFD_DN: begin
				if (fr_pulse) begin
					pfd_nxt = SPD_PFD_IDLE;
				end
			end
			default: begin
				pfd_nxt = SPD_PFD_IDLE;
			end
		endcase
	end

	// pump drives decode from the next state so they stay aligned to it
	logic pump_hi_nxt;
	logic pump_lo_nxt;
	logic pump_hi_r;
	logic pump_lo_r;
	logic pump_oe_n_nxt;
	logic pump_oe_n_r;

	assign pump_hi_nxt = (pfd_nxt == SPD_PFD_UP);
	assign pump_lo_nxt = (pfd_nxt == SPD_PFD_DN);
	// enable has its own flop so the pin never sees a decode glitch
	assign pump_oe_n_nxt = ~(pump_hi_nxt | pump_lo_nxt);

	// detector state and pump flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pfd_r       <= SPD_PFD_IDLE;
			pump_hi_r   <= 1'h0;
			pump_lo_r   <= 1'h0;
			pump_oe_n_r <= 1'h1;
		end else begin
			pfd_r       <= pfd_nxt;
			pump_hi_r   <= pump_hi_nxt;
			pump_lo_r   <= pump_lo_nxt;
			pump_oe_n_r <= pump_oe_n_nxt;
		end
	end

	a_pump_up: assert property (
		(pfd_r == SPD_PFD_IDLE && fr_pulse && !fv_r) |=> !pump_oe_n && pump_out)
		else $error("reference lead did not drive pump high");

	a_pump_down: assert property (
		(pfd_r == SPD_PFD_IDLE && fv_r && !fr_pulse) |=> !pump_oe_n && !pump_out)
		else $error("feedback lead did not drive pump low");

	a_pump_release: assert property (
		(pfd_r == SPD_PFD_UP && fv_r) |=> pump_oe_n)
		else $error("pump not released after edges aligned");

	a_ext_matches: assert property (
		(ext_pump_up == (!pump_oe_n && pump_out)) && (ext_pump_dn == (!pump_oe_n && !pump_out)))
		else $error("external pump output disagrees with on-chip pump");

	c_pump_up: cover property (pump_hi_r ##[1:300] pump_oe_n);
	c_pump_dn: cover property (pump_lo_r ##[1:300] pump_oe_n);

	// ************************************************************
	// outputs
	// ************************************************************
	// on-chip pump: enable low while driving, level follows direction
	assign pump_oe_n   = pump_oe_n_r;
	assign pump_out    = pump_hi_r;
	// external pump gets separate up and down levels
	assign ext_pump_up = pump_hi_r;
	assign ext_pump_dn = pump_lo_r;

	// monitors and prescaler control
	assign mod_ctrl               = mod_r;
	assign feedback_divided_freq  = fv_r;
	assign reference_divided_freq = fr_pulse;
	assign swallow_value          = swal_set;
	assign prog_value             = prog_set;

endmodule

// ---- verification/spd_prescaler_model.sv ----
// spd_prescaler_model: behavioural dual-modulus prescaler that feeds the divider input of the core
module spd_prescaler_model #(
	parameter int MOD  = 4,
	parameter int TICK = 2
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// modulus control from the core
	input  wire logic mod_ctrl,
	// divided output towards the core
	output logic      presc_out
);
	timeunit 1ns;
	timeprecision 1ps;

	int   sub_r;
	int   cnt_r;
	logic ext_r;

	// ************************************************************
	// modulus counter
	// ************************************************************
	// one tick stands for one oscillator cycle and lasts TICK clocks
	// mod_ctrl is looked at only at the end of a period, as a real prescaler does
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sub_r <= 0;
			cnt_r <= 0;
			ext_r <= 1'h0;
		end else if (sub_r != TICK - 1) begin
			sub_r <= sub_r + 1;
		end else begin
			sub_r <= 0;
			if (cnt_r != MOD - 1) begin
				cnt_r <= cnt_r + 1;
			end else if (mod_ctrl && !ext_r) begin
				ext_r <= 1'h1; // high modulus: one extra tick
			end else begin
				cnt_r <= 0;
				ext_r <= 1'h0;
			end
		end
	end

	// high for the first half, so each level lasts at least two clocks
	assign presc_out = (cnt_r < MOD / 2);
endmodule

// ---- verification/serial_pll_divider_core_bench.sv ----
// serial_pll_divider_core_bench: self-checking bench for the synthesizer core
`define SPD_CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin num_errors++; \
	$display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end

module serial_pll_divider_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import spd_pkg::*;

	localparam int MOD  = 4;
	localparam int TICK = 2;

	logic        clk      = 1'h0;
	logic        rst_n    = 1'h0;
	logic        ser_clk  = 1'h0;
	logic        ser_data = 1'h0;
	logic        strobe   = 1'h0;
	logic [2:0]  sel      = 3'h0;
	logic [1:0]  osc_ph   = 2'h0;
	logic        presc;
	logic        mod_ctrl;
	logic        ref_pulse;
	logic        fb_pulse;
	logic        pump_out;
	logic        pump_oe_n;
	logic        ext_up;
	logic        ext_dn;
	logic [6:0]  swal;
	logic [9:0]  prog;
	logic [16:0] cur      = SPD_LATCH_RST;
	spd_pfd_t    mst;
	logic        saw_up   = 1'h0;
	logic        saw_dn   = 1'h0;
	int          num_errors = 0;
	int          n_tests    = 0;

	always #12.5 clk = ~clk;

	// oscillator stand-in: two clocks high, two clocks low
	always @(posedge clk) begin
		osc_ph <= osc_ph + 2'h1;
	end

	spd_core i_dut (
		.clk                   (clk),
		.rst_n                 (rst_n),
		.ser_clk               (ser_clk),
		.ser_data              (ser_data),
		.latch_transfer_strobe (strobe),
		.ref_ratio_select_0    (sel[0]),
		.ref_ratio_select_1    (sel[1]),
		.ref_ratio_select_2    (sel[2]),
		.osc_in                (osc_ph[1]),
		.prescaler_in          (presc),
		.mod_ctrl              (mod_ctrl),
		.reference_divided_freq(ref_pulse),
		.feedback_divided_freq (fb_pulse),
		.pump_out              (pump_out),
		.pump_oe_n             (pump_oe_n),
		.ext_pump_up           (ext_up),
		.ext_pump_dn           (ext_dn),
		.swallow_value         (swal),
		.prog_value            (prog)
	);

	spd_prescaler_model #(.MOD(MOD), .TICK(TICK)) i_presc (
		.clk      (clk),
		.rst_n    (rst_n),
		.mod_ctrl (mod_ctrl),
		.presc_out(presc)
	);

	// ************************************************************
	// expectation helpers
	// ************************************************************
	function automatic spd_pfd_t pfd_next(spd_pfd_t s, logic r, logic v);
		if (s == SPD_PFD_IDLE && r != v) return r ? SPD_PFD_UP : SPD_PFD_DN;
		if ((s == SPD_PFD_UP && v) || (s == SPD_PFD_DN && r)) return SPD_PFD_IDLE;
		return s;
	endfunction

	// divide ratio for a select code: 8, 16, then 64 up to 2048
	function automatic int ref_ratio(int code);
		return (code < 2) ? (8 << code) : (16 << code);
	endfunction

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// phase detector model stepped by the divided pulses, so every pump change is checked
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) mst <= SPD_PFD_IDLE;
		else mst <= pfd_next(mst, ref_pulse, fb_pulse);
	end

	always @(negedge clk) begin
		if (rst_n) begin
			saw_up |= (mst == SPD_PFD_UP);
			saw_dn |= (mst == SPD_PFD_DN);
			`SPD_CHK("pump", {mst == SPD_PFD_IDLE, mst == SPD_PFD_UP, mst == SPD_PFD_DN, mst != SPD_PFD_DN},
				{pump_oe_n, ext_up, ext_dn, pump_out | pump_oe_n})
		end
	end

	// ************************************************************
	// bus-free drivers
	// ************************************************************
	task automatic wait_pulse(input bit use_fb);
		int k;
		for (k = 0; k < 9000; k++) begin
			@(posedge clk);
			if ((use_fb ? fb_pulse : ref_pulse) === 1'h1) return;
		end
		num_errors++;
		$display("[ERR] pulse wait expected 1 seen 0");
		report_and_stop();
	endtask

	// clocks from one pulse to the next
	task automatic measure(input bit use_fb, input int exp, input string nm);
		int k;
		wait_pulse(use_fb);
		for (k = 1; k < 9000; k++) begin
			@(posedge clk);
			if ((use_fb ? fb_pulse : ref_pulse) === 1'h1) break;
		end
		`SPD_CHK(nm, exp, k)
		// a used-up limit has just been counted as a mismatch above
		if (k >= 9000) report_and_stop();
	endtask

	// pre junk bits go first; they must fall out of the top of the shift register
	task automatic send_word(input logic [16:0] w, input int pre);
		int i;
		for (i = -pre; i < 17; i++) begin
			@(posedge clk);
			ser_data <= (i < 0) ? 1'h1 : w[16 - i]; // most significant bit first
			repeat (3) @(posedge clk);
			ser_clk <= 1'h1; // one bit per rising edge
			repeat (3) @(posedge clk);
			ser_clk <= 1'h0;
		end
		repeat (5) @(posedge clk);
		`SPD_CHK("latch held", cur, {prog, swal})
		strobe <= 1'h1;
		repeat (3) @(posedge clk);
		strobe <= 1'h0;
		repeat (4) @(posedge clk);
		cur = w;
		`SPD_CHK("swallow", w[6:0], swal)
		`SPD_CHK("prog", w[16:7], prog)
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		int t;
		int n;
		int a;
		void'($urandom(80277));
		repeat (8) @(posedge clk);
		`SPD_CHK("reset", {6'h04, SPD_LATCH_RST},
			{mod_ctrl, ref_pulse, fb_pulse, pump_oe_n, ext_up, ext_dn, prog, swal})
		repeat (8) @(posedge clk);
		rst_n <= 1'h1;
		// pulse-swallow corners first, then random settings
		for (t = 0; t < 6; t++) begin
			if (t == 0) begin
				n = 5; // host keeps the programmable value at five or more
				a = 0;
			end else if (t == 1) begin
				n = 128;
				a = 127; // largest swallow value
			end else begin
				n = 5 + $urandom % 56;
				a = $urandom % n; // below 64, so swallow bit seven stays clear as 64/65 mode needs
			end
			send_word({n[9:0], a[6:0]}, t);
			wait_pulse(1'h1);
			measure(1'h1, TICK * (n * MOD + a), "feedback period");
		end
		send_word(17'h1ffff, 0); // full-scale fields
		send_word(17'h00a03, 0);
		// reference ratios in ascending code order; a new code applies from the next reload
		for (t = 0; t < 8; t++) begin
			sel <= t[2:0];
			wait_pulse(1'h0);
			wait_pulse(1'h0);
			measure(1'h0, 4 * ref_ratio(t), "reference period");
		end
		`SPD_CHK("pump up seen", 1'h1, saw_up)
		`SPD_CHK("pump down seen", 1'h1, saw_dn)
		report_and_stop();
	end
endmodule
